// >>> src/dmac_pkg.sv
// Constants shared by the divide and multiply-accumulate datapath.
// Assumes a single core clock and an issuing pipeline on the same clock.
// Notes on behaviour
// - Signed doubleword divide: quotient low, remainder high
// - Unsigned doubleword divide writes quotient and remainder
// - Signed word divide, results sign-extended from bit 31
// - Unsigned word divide, results sign-extended from bit 31
// - Divides never overflow; divide-by-zero results arbitrary
// - Doubleword ops reserved in 32-bit user/supervisor mode
// - Multiply-accumulate multiplies 16-bit signed operands
// - Product added to full signed accumulator, written back
// - Multiply-accumulate never raises an overflow
// - Multiply-accumulate waits after earlier result producers
`default_nettype none
package dmac_pkg;
  // ==========================================================
  // Widths
  localparam int XLEN  = 64;
  localparam int WLEN  = 32;
  localparam int HLEN  = 16;
  localparam int HAZ_W = 7;
  // ==========================================================
  // Instruction fields
  localparam logic [5:0] OPC_SPECIAL     = 6'h00;
  localparam logic [9:0] ZERO_FIELD      = 10'h000;
  localparam logic [5:0] FUNC_SDIV_DWORD = 6'h1e;
  localparam logic [5:0] FUNC_UDIV_DWORD = 6'h1f;
  localparam logic [5:0] FUNC_SDIV_WORD  = 6'h1a;
  localparam logic [5:0] FUNC_UDIV_WORD  = 6'h1b;
  localparam logic [5:0] FUNC_MAC_HALF   = 6'h29;
  // ==========================================================
  // Wait before a multiply-accumulate, in cycles
  localparam logic [HAZ_W-1:0] WAIT_WORD_PRODUCT  = 7'h01;
  localparam logic [HAZ_W-1:0] WAIT_DWORD_PRODUCT = 7'h04;
  localparam logic [HAZ_W-1:0] WAIT_WORD_DIVIDE   = 7'h24;
  localparam logic [HAZ_W-1:0] WAIT_DWORD_DIVIDE  = 7'h44;
  localparam logic [HAZ_W-1:0] WAIT_MOVE_FROM     = 7'h02;
  localparam logic [HAZ_W-1:0] WAIT_NONE          = 7'h00;
  // ==========================================================
  // Reset values
  localparam logic [XLEN-1:0] RESULT_RESET = 64'h0;
endpackage : dmac_pkg
`default_nettype wire

// >>> src/div_link_if.sv
// Link between the datapath control and the iterative divider.
// Assumes both ends on the core clock.
`default_nettype none
interface div_link_if #(parameter int W = 64);
  logic         start;
  logic         word;
  logic [W-1:0] dividend;
  logic [W-1:0] divisor;
  logic [W-1:0] quotient;
  logic [W-1:0] remainder;
  logic         done;
  logic         busy;
  modport core (input start, word, dividend, divisor,
                output quotient, remainder, done, busy);
  modport ctrl (output start, word, dividend, divisor,
                input quotient, remainder, done, busy);
endinterface : div_link_if
`default_nettype wire

// >>> src/div_iter.sv
// Restoring unsigned divider, one quotient bit per clock.
// Assumes magnitudes on its inputs; sign handling is done by the caller.
`default_nettype none
module div_iter #(
  parameter int W = 64
) (
  input  wire logic    mclk,
  input  wire logic    rst,
  div_link_if.core     lnk
);
  localparam int CW = $clog2(W) + 1;
  localparam logic [CW-1:0] STEPS_DWORD = CW'(W);
  localparam logic [CW-1:0] STEPS_WORD  = CW'(W / 2);
  localparam logic [CW-1:0] STEP_LAST   = CW'(1);

  logic [W:0]   rem;
  logic [W-1:0] quo;
  logic [W-1:0] dsr;
  logic [CW-1:0] cnt;
  logic         busy;
  logic         done;

  // ==========================================================
  // Trial subtraction
  wire [W:0]   shifted = {rem[W-1:0], quo[W-1]};
  wire [W:0]   trial   = shifted - {1'b0, dsr};
  wire         fits    = ~trial[W];
  wire [W-1:0] dvd_in  = lnk.word ? {lnk.dividend[W/2-1:0], {(W/2){1'b0}}} : lnk.dividend;
  wire [W-1:0] dsr_in  = lnk.word ? {{(W/2){1'b0}}, lnk.divisor[W/2-1:0]} : lnk.divisor;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rem  <= '0;
      quo  <= '0;
      dsr  <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (lnk.start) begin
        rem  <= '0;
        quo  <= dvd_in;
        dsr  <= dsr_in;
        cnt  <= lnk.word ? STEPS_WORD : STEPS_DWORD;
        busy <= 1'b1;
      end else if (busy) begin
        rem <= fits ? trial : shifted;
        quo <= {quo[W-2:0], fits};
        cnt <= cnt - STEP_LAST;
        if (cnt == STEP_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign lnk.quotient  = quo;
  assign lnk.remainder = rem[W-1:0];
  assign lnk.done      = done;
  assign lnk.busy      = busy;
endmodule : div_iter
`default_nettype wire

// >>> src/mac_half.sv
// Halfword signed multiply added to a 64-bit accumulator.
// Uses only bits 15:0 of each operand; the upper operand bits are ignored.
`default_nettype none
module mac_half #(
  parameter int W = 64,
  parameter int H = 16
) (
  input  wire logic [W-1:0] acc,
  input  wire logic [W-1:0] opa,
  input  wire logic [W-1:0] opb,
  output logic      [W-1:0] sum
);
  wire signed [2*H-1:0] prod = $signed(opa[H-1:0]) * $signed(opb[H-1:0]);
  wire        [W-1:0]   prod_ext = {{(W-2*H){prod[2*H-1]}}, prod};
  // Wraps silently, no overflow signalled
  assign sum = acc + prod_ext;
endmodule : mac_half
`default_nettype wire

// >>> src/divide_and_mac_unit.sv
// Divide and multiply-accumulate datapath with its two result registers.
// Assumes the pipeline issues one instruction per pulse on the core clock.
`default_nettype none
module divide_and_mac_unit #(
  parameter int W = dmac_pkg::XLEN
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         issue_valid,
  input  wire logic [5:0]   issue_opcode,
  input  wire logic [9:0]   issue_zero_field,
  input  wire logic [5:0]   issue_func,
  input  wire logic [W-1:0] operand_a,
  input  wire logic [W-1:0] operand_b,
  input  wire logic         mode_64bit,
  input  wire logic         mode_kernel,
  input  wire logic         word_product_ops,
  input  wire logic         dword_product_ops,
  input  wire logic         move_from_quot_acc,
  input  wire logic         move_from_rem_reg,
  output logic [W-1:0]      quot_acc_reg,
  output logic [W-1:0]      rem_reg,
  output logic [W-1:0]      move_data,
  output logic              div_busy,
  output logic              mac_hold,
  output logic              op_done,
  output logic              reserved_exc,
  output logic              issue_reject
);
  localparam int HW = dmac_pkg::HAZ_W;
  localparam int WL = dmac_pkg::WLEN;

  div_link_if #(.W(W)) lnk ();

  // ==========================================================
  // Decode
  wire special  = issue_valid && (issue_opcode == dmac_pkg::OPC_SPECIAL)
                  && (issue_zero_field == dmac_pkg::ZERO_FIELD);
  wire is_sdivd = special && (issue_func == dmac_pkg::FUNC_SDIV_DWORD);
  wire is_udivd = special && (issue_func == dmac_pkg::FUNC_UDIV_DWORD);
  wire is_sdivw = special && (issue_func == dmac_pkg::FUNC_SDIV_WORD);
  wire is_udivw = special && (issue_func == dmac_pkg::FUNC_UDIV_WORD);
  wire is_mac   = special && (issue_func == dmac_pkg::FUNC_MAC_HALF);
  wire is_dword = is_sdivd || is_udivd || is_mac;
  wire is_div   = is_sdivd || is_udivd || is_sdivw || is_udivw;
  wire mode_ok  = mode_64bit || mode_kernel;
  wire rsv      = is_dword && !mode_ok;

  // ==========================================================
  // Hazard spacing before a multiply-accumulate
  logic [HW-1:0] haz_cnt;
  logic          div_run;
  wire           haz_clear = (haz_cnt == dmac_pkg::WAIT_NONE);
  wire           div_go    = is_div && !rsv && !div_run;
  wire           mac_go    = is_mac && !rsv && haz_clear && !div_run;
  wire           reject    = (is_div && !rsv && div_run) || (is_mac && !rsv && !mac_go);
  wire           mf_any    = move_from_quot_acc || move_from_rem_reg;

  logic [HW-1:0] haz_load;
  always_comb begin
    haz_load = dmac_pkg::WAIT_NONE;
    if (mf_any && dmac_pkg::WAIT_MOVE_FROM > haz_load) begin
      haz_load = dmac_pkg::WAIT_MOVE_FROM;
    end
    if (word_product_ops && dmac_pkg::WAIT_WORD_PRODUCT > haz_load) begin
      haz_load = dmac_pkg::WAIT_WORD_PRODUCT;
    end
    if (dword_product_ops && dmac_pkg::WAIT_DWORD_PRODUCT > haz_load) begin
      haz_load = dmac_pkg::WAIT_DWORD_PRODUCT;
    end
    if (div_go && (is_sdivw || is_udivw)) begin
      haz_load = dmac_pkg::WAIT_WORD_DIVIDE;
    end
    if (div_go && (is_sdivd || is_udivd)) begin
      haz_load = dmac_pkg::WAIT_DWORD_DIVIDE;
    end
  end

  wire [HW-1:0] haz_dec  = haz_clear ? dmac_pkg::WAIT_NONE : haz_cnt - HW'(1);
  wire [HW-1:0] next_haz = (haz_load > haz_dec) ? haz_load : haz_dec;

  // ==========================================================
  // Operand preparation for the divider
  logic         q_neg;
  logic         r_neg;
  logic         word_op;
  wire          signed_op = is_sdivd || is_sdivw;
  wire          word_in   = is_sdivw || is_udivw;
  wire [W-1:0]  a_ext     = word_in ? {{(W-WL){operand_a[WL-1]}}, operand_a[WL-1:0]} : operand_a;
  wire [W-1:0]  b_ext     = word_in ? {{(W-WL){operand_b[WL-1]}}, operand_b[WL-1:0]} : operand_b;
  wire          a_neg     = signed_op && a_ext[W-1];
  wire          b_neg     = signed_op && b_ext[W-1];
  wire [W-1:0]  a_mag     = a_neg ? (~a_ext + W'(1)) : a_ext;
  wire [W-1:0]  b_mag     = b_neg ? (~b_ext + W'(1)) : b_ext;

  assign lnk.start    = div_go;
  assign lnk.word     = word_in;
  assign lnk.dividend = a_mag;
  assign lnk.divisor  = b_mag;

  div_iter #(.W(W)) u_div (
    .mclk (mclk),
    .rst  (rst),
    .lnk  (lnk)
  );

  // ==========================================================
  // Result fix-up
  wire [W-1:0] q_sgn   = q_neg ? (~lnk.quotient + W'(1)) : lnk.quotient;
  wire [W-1:0] r_sgn   = r_neg ? (~lnk.remainder + W'(1)) : lnk.remainder;
  wire [W-1:0] q_final = word_op ? {{(W-WL){q_sgn[WL-1]}}, q_sgn[WL-1:0]} : q_sgn;
  wire [W-1:0] r_final = word_op ? {{(W-WL){r_sgn[WL-1]}}, r_sgn[WL-1:0]} : r_sgn;

  wire [W-1:0] mac_sum;
  mac_half #(.W(W), .H(dmac_pkg::HLEN)) u_mac (
    .acc (quot_acc_reg),
    .opa (operand_a),
    .opb (operand_b),
    .sum (mac_sum)
  );

  wire [W-1:0] next_quot = lnk.done ? q_final : (mac_go ? mac_sum : quot_acc_reg);
  wire [W-1:0] next_rem  = lnk.done ? r_final : rem_reg;
  wire [W-1:0] next_move = move_from_quot_acc ? quot_acc_reg :
                           (move_from_rem_reg ? rem_reg : move_data);

  // ==========================================================
  // Divide sign state
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q_neg   <= 1'b0;
      r_neg   <= 1'b0;
      word_op <= 1'b0;
    end else if (div_go) begin
      q_neg   <= a_neg ^ b_neg;
      r_neg   <= a_neg;
      word_op <= word_in;
    end
  end

  // ==========================================================
  // Divider run flag, set at accept and held to completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_run <= 1'b0;
    end else if (div_go) begin
      div_run <= 1'b1;
    end else if (lnk.done) begin
      div_run <= 1'b0;
    end
  end

  // ==========================================================
  // Result registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      quot_acc_reg <= dmac_pkg::RESULT_RESET;
      rem_reg      <= dmac_pkg::RESULT_RESET;
      move_data    <= dmac_pkg::RESULT_RESET;
    end else begin
      quot_acc_reg <= next_quot;
      rem_reg      <= next_rem;
      move_data    <= next_move;
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      haz_cnt      <= dmac_pkg::WAIT_NONE;
      div_busy     <= 1'b0;
      mac_hold     <= 1'b0;
      op_done      <= 1'b0;
      reserved_exc <= 1'b0;
      issue_reject <= 1'b0;
    end else begin
      haz_cnt      <= next_haz;
      div_busy     <= (div_go || div_run) && !lnk.done;
      mac_hold     <= (next_haz != dmac_pkg::WAIT_NONE) || ((div_go || div_run) && !lnk.done);
      op_done      <= lnk.done || mac_go;
      reserved_exc <= rsv;
      issue_reject <= reject;
    end
  end
endmodule : divide_and_mac_unit
`default_nettype wire

// >>> dv/dmac_properties.sv
// Port-level assertions for the divide and multiply-accumulate unit.
// Assumes a by-name bind onto the unit's top module.
`default_nettype none
module dmac_properties #(parameter int W = 64) (
  input wire logic         mclk,
  input wire logic         rst,
  input wire logic         issue_valid,
  input wire logic [5:0]   issue_opcode,
  input wire logic [9:0]   issue_zero_field,
  input wire logic [5:0]   issue_func,
  input wire logic [W-1:0] operand_a,
  input wire logic [W-1:0] operand_b,
  input wire logic         mode_64bit,
  input wire logic         mode_kernel,
  input wire logic         dword_product_ops,
  input wire logic         move_from_quot_acc,
  input wire logic [W-1:0] quot_acc_reg,
  input wire logic         div_busy,
  input wire logic         mac_hold,
  input wire logic         op_done,
  input wire logic         reserved_exc,
  input wire logic         issue_reject
);
  // =====
  // Decode
  wire         ok   = issue_valid && issue_opcode == 6'h00 && issue_zero_field == 10'h000;
  wire         priv = mode_64bit || mode_kernel;
  wire         dd   = ok && issue_func[5:1] == 5'h0f;
  wire         wd   = ok && issue_func[5:1] == 5'h0d;
  wire         mac  = ok && issue_func == 6'h29;
  wire [W-1:0] prod = $signed(operand_a[15:0]) * $signed(operand_b[15:0]);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // =====
  // Checks
  mac_sum_a: assert property (mac && priv && !mac_hold |=> op_done &&
    quot_acc_reg == $past(quot_acc_reg) + $past(prod)) else $error("mac sum wrong");
  dword_time_a: assert property (dd && priv && !div_busy |=>
    div_busy [*8] ##58 op_done) else $error("doubleword divide timing wrong");
  word_time_a: assert property (wd && !div_busy |-> ##34 op_done && !div_busy)
    else $error("word divide timing wrong");
  resv_op_a: assert property (((dd && !div_busy) || (mac && !mac_hold)) && !priv
    |=> reserved_exc && !op_done) else $error("reserved op not flagged");
  no_exc_a: assert property (ok && priv |=> !reserved_exc)
    else $error("exception in privileged mode");
  dprod_wait_a: assert property (dword_product_ops |=> mac_hold [*4])
    else $error("product wait short");
  mac_reject_a: assert property (mac && priv && mac_hold && !div_busy |=>
    issue_reject && $stable(quot_acc_reg)) else $error("held mac not rejected");
  move_wait_a: assert property (move_from_quot_acc |=> mac_hold [*2])
    else $error("move-from wait short");
  cover property (dd && priv && !div_busy);
  cover property (mac && priv && !mac_hold);
  cover property (issue_reject);
endmodule : dmac_properties
bind divide_and_mac_unit dmac_properties #(.W(W)) props (.*);
`default_nettype wire

// >>> dv/pipe_model.sv
// Pipeline stand-in issuing one instruction or event per cycle.
// Assumes the bench calls op back to back; drives at falling edges.
`default_nettype none
module pipe_model (
  input  wire logic   mclk,
  output logic        issue_valid,
  output logic [5:0]  issue_opcode,
  output logic [9:0]  issue_zero_field,
  output logic [5:0]  issue_func,
  output logic [63:0] operand_a,
  output logic [63:0] operand_b,
  output logic        dword_product_ops,
  output logic        word_product_ops,
  output logic        move_from_quot_acc,
  output logic        move_from_rem_reg
);
  // =====
  // Issue
  initial begin
    {issue_valid, issue_opcode, issue_zero_field, issue_func} = '0;
    {operand_a, operand_b} = '0;
    {dword_product_ops, word_product_ops, move_from_quot_acc, move_from_rem_reg} = '0;
  end
  function automatic logic [63:0] fit(logic v, m, logic [63:0] x, o);
    return !v ? ~o : m ? 64'($signed(x[15:0])) : x;
  endfunction : fit
  task automatic op(logic v, logic [5:0] f, logic [63:0] x, y, logic [3:0] ev);
    @(negedge mclk);
    issue_valid <= v;
    issue_func  <= f;
    operand_a   <= fit(v, f == 6'h29, x, operand_a);
    operand_b   <= fit(v, f == 6'h29, y, operand_b);
    {dword_product_ops, word_product_ops, move_from_quot_acc, move_from_rem_reg} <= ev;
  endtask : op
endmodule : pipe_model
`default_nettype wire

// >>> dv/divide_and_mac_unit_tb.sv
// Self-checking bench for the divide and multiply-accumulate unit.
// Assumes pipe_model issues work; one queue carries expected results.
`default_nettype none
`define CHK(s, x, y) begin comparisons++; if ((y) !== (x)) begin n_fail++; \
  $display("[FAIL] %s exp %h got %h", s, x, y); end end
module divide_and_mac_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic         mclk = 1'b0, rst = 1'b1, mode_64bit = 1'b1, mode_kernel = 1'b0;
  wire          issue_valid, dword_product_ops, word_product_ops;
  wire          move_from_quot_acc, move_from_rem_reg;
  wire [5:0]    issue_opcode, issue_func;
  wire [9:0]    issue_zero_field;
  wire [63:0]   operand_a, operand_b, quot_acc_reg, rem_reg, move_data;
  wire          div_busy, mac_hold, op_done, reserved_exc, issue_reject;
  int           n_fail = 0, comparisons = 0;
  logic [63:0]  seed = 64'h3d, acc = '0, rm = '0;
  logic [132:0] e, pend, sb[$];
  logic [5:0]   fl[5] = '{6'h1f, 6'h1e, 6'h1f, 6'h1a, 6'h1b};
  divide_and_mac_unit dut (.*);
  pipe_model pm (.*);
  // =====
  // Helpers
  initial forever #5 mclk = ~mclk;
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction : rnd
  function automatic logic [127:0] ediv(logic [5:0] f, logic [63:0] x, y);
    logic [31:0] q, r;
    if (f == 6'h1e) return {$signed(x) / $signed(y), $signed(x) % $signed(y)};
    if (f == 6'h1f) return {x / y, x % y};
    if (f[0]) {q, r} = {x[31:0] / y[31:0], x[31:0] % y[31:0]};
    else {q, r} = {$signed(x[31:0])/$signed(y[31:0]), $signed(x[31:0])%$signed(y[31:0])};
    return {{32{q[31]}}, q, {32{r[31]}}, r};
  endfunction : ediv
  task automatic mac(logic [2:0] k);
    logic [63:0] x, y;
    logic signed [63:0] p;
    x = rnd();
    y = rnd();
    p = $signed(x[15:0]) * $signed(y[15:0]);
    if (k[2]) acc += p;
    sb.push_back({k, k[2], 1'b0, acc, 64'h0});
    pm.op(1'b1, 6'h29, x, y, 4'h0);
  endtask : mac
  task automatic div(logic [5:0] f, logic [63:0] x, y, logic [2:0] k);
    logic [127:0] d;
    d = ediv(f, x, y);
    if (k[2]) {acc, rm} = d;
    pend = {k, {2{k[2] && y != 0}}, d};
    pm.op(1'b1, f, x, y, 4'h0);
  endtask : div
  task automatic idle(logic [3:0] ev);
    pm.op(1'b0, 6'h0, 64'h0, 64'h0, ev);
  endtask : idle
  task automatic settle;
    idle(4'h0);
    for (int n = 0; n < 200 && (div_busy | mac_hold) !== 1'b0; n++) begin
      @(posedge mclk);
      #1;
    end
    `CHK("settle", 1'b0, div_busy | mac_hold)
  endtask : settle
  task automatic give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // =====
  // Result watcher
  always @(posedge mclk) begin
    #1;
    if ((op_done | reserved_exc | issue_reject) !== 1'b0 && !rst) begin
      e = sb.size() ? sb.pop_front() : '0;
      `CHK("flags", e[132:130], {op_done, reserved_exc, issue_reject})
      if (e[129]) `CHK("quot", e[127:64], quot_acc_reg)
      if (e[128]) `CHK("rem", e[63:0], rem_reg)
    end
  end
  // =====
  // Sequence
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      div(fl[i], rnd() | {i == 1, 63'h0}, i == 0 ? 64'h0 : i == 4 ? 64'h1 : rnd() >> (i * 8),
          3'b100);
      mac(3'b001);
      sb.push_back(pend);
      idle(4'h0);
      repeat (fl[i][2] ? 66 : 34) @(posedge mclk);
      #1 `CHK("hold", 1'b1, mac_hold)
      @(posedge mclk);
      #1 `CHK("free", 1'b0, mac_hold)
      settle;
    end
    idle(4'b0010);
    idle(4'b0001);
    `CHK("move quot", acc, move_data)
    @(posedge mclk);
    #1 `CHK("move rem", rm, move_data)
    repeat (2) mac(3'b001);
    repeat (4) mac(3'b100);
    idle(4'b1000);
    mac(3'b001);
    settle;
    idle(4'b0100);
    mac(3'b001);
    mac(3'b100);
    repeat (3) idle(4'h0);
    mode_64bit = 1'b0;
    div(6'h1e, rnd(), 64'h5, 3'b010);
    sb.push_back(pend);
    mac(3'b010);
    div(6'h1b, rnd(), 64'h7, 3'b100);
    sb.push_back(pend);
    settle;
    @(negedge mclk) mode_kernel = 1'b1;
    mac(3'b100);
    settle;
    pm.issue_zero_field <= 10'h001;
    div(6'h1f, rnd(), 64'h3, 3'b000);
    idle(4'h0);
    pm.issue_zero_field <= 10'h000;
    `CHK("ignored", 1'b0, div_busy)
    settle;
    `CHK("queue", 1'b1, sb.size() == 0)
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    give_verdict;
  end
endmodule : divide_and_mac_unit_tb
`default_nettype wire
